// File: pbrc_defs.vh
/*
  shared constants for the buffered reload control of one pwm channel.
  assumes inclusion by bare name from the design file.
*/
`ifndef PBRC_DEFS_VH
`define PBRC_DEFS_VH
`define PBRC_VAL_W 16
`define PBRC_SRC_W 2
`define PBRC_NSRC 4
`define PBRC_RST_VAL 16'h0000
`define PBRC_RST_BIT 1'b0
`define PBRC_MODE_IMMEDIATE 1'b0
`define PBRC_MODE_TRIGGERED 1'b1
`define PBRC_ST_IDLE 2'h0
`define PBRC_ST_ARMED 2'h1
`define PBRC_ST_WAIT_TRIG 2'h2
`define PBRC_ST_TRIGGERED 2'h3
`endif

// File: pbrc_reload.v
/*
  double-buffered reload control of one 16-bit pwm channel: holding and
  operating copies of phase, duty, period, offset and the offset-mode bit.
  assumes software writes arrive as single-cycle write strobes on clk_i, and
  that other channels present their buffer-load events as one-cycle pulses.
*/
`timescale 1ns/100ps
`include "pbrc_defs.vh"

// Function
// - holding and operating copies for five values
// - writes touch only the holding copies
// - trigger mode bit picks immediate or triggered
// - never load without load arm set
// - all copies transfer in one cycle
// - immediate mode loads at next period event
// - triggered mode waits for other channel pulse
// - two-bit field selects the trigger source
// - triggered load at period event after trigger
// - a load clears load arm unless armed again in that cycle
// - arm coinciding with period event waits one
module pbrc_reload #(
  parameter VAL_W = `PBRC_VAL_W,
  parameter NSRC = `PBRC_NSRC
) (
  // clock, reset and channel counter
  input wire clk_i,
  input wire sys_rst_i,
  input wire [VAL_W-1:0] pwm_counter_i,
  // software writes to the holding copies
  input wire [VAL_W-1:0] phase_wdata_i,
  input wire phase_we_i,
  input wire [VAL_W-1:0] duty_wdata_i,
  input wire duty_we_i,
  input wire [VAL_W-1:0] period_wdata_i,
  input wire period_we_i,
  input wire [VAL_W-1:0] offset_wdata_i,
  input wire offset_we_i,
  input wire offset_mode_option_i,
  input wire offset_mode_we_i,
  // reload control and peer load events
  input wire load_arm_set_i,
  input wire load_trigger_mode_i,
  input wire [`PBRC_SRC_W-1:0] trigger_source_select_i,
  input wire [NSRC-1:0] peer_load_event_i,
  // holding copies, as software reads them back
  output wire [VAL_W-1:0] phase_hold_o,
  output wire [VAL_W-1:0] duty_hold_o,
  output wire [VAL_W-1:0] period_hold_o,
  output wire [VAL_W-1:0] offset_hold_o,
  output wire offset_mode_hold_o,
  // operating copies, as the pwm logic uses them
  output wire [VAL_W-1:0] phase_value_pair_o,
  output wire [VAL_W-1:0] duty_value_pair_o,
  output wire [VAL_W-1:0] period_operating_value_o,
  output wire [VAL_W-1:0] offset_value_pair_o,
  output wire offset_mode_option_o,
  // arming status and exported load event
  output reg load_arm_o,
  output reg load_event_o
);

  // state codes of the reload sequencer
  localparam [1:0] ST_IDLE = `PBRC_ST_IDLE;
  localparam [1:0] ST_ARMED = `PBRC_ST_ARMED;
  localparam [1:0] ST_WAIT_TRIG = `PBRC_ST_WAIT_TRIG;
  localparam [1:0] ST_TRIGGERED = `PBRC_ST_TRIGGERED;

  // sequencer state and next values
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg load_arm_d;
  reg do_load;
  wire period_event;
  wire trig_sel;
  wire trig_mode_sel;

  // period event
  // compares against the operating period, so a new period waiting in the
  // holding copy never moves the event that is about to load it
  assign period_event = (pwm_counter_i == period_operating_value_o);

  // source select
  // peer events are single-cycle pulses already, so no edge detect is needed
  assign trig_sel = peer_load_event_i[trigger_source_select_i];

  assign trig_mode_sel = (load_trigger_mode_i == `PBRC_MODE_TRIGGERED);

  // idle: not armed. armed: immediate, ready for the next period event.
  // wait_trig: triggered mode, no trigger seen yet. triggered: ready for
  // the next period event. arming always passes through a state change, so
  // a period event or trigger in the arming cycle itself is never acted on.
  // limitation: only one reload can be pending; further arm pulses while
  // armed change nothing before the load cycle, including a change of the trigger mode.
  always @* begin
    state_d = state_q;
    do_load = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (load_arm_set_i) begin
          state_d = trig_mode_sel ? ST_WAIT_TRIG : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (period_event) begin
          do_load = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_WAIT_TRIG: begin
        // wait for trigger
        // a trigger on our own period event only readies the next one
        if (trig_sel) begin
          state_d = ST_TRIGGERED;
        end
      end
      ST_TRIGGERED: begin
        if (period_event) begin
          do_load = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // arm required
    // busy states imply the arm flag; the guard keeps a bad state from loading
    if (!load_arm_o && state_q != ST_IDLE) begin
      do_load = 1'b0;
    end

    // an arm pulse in the load cycle starts a fresh sequence at once
    if (do_load && load_arm_set_i) begin
      state_d = trig_mode_sel ? ST_WAIT_TRIG : ST_ARMED;
    end
  end

  // load clears arm
  // set wins over the clear, so an arm pulse in the load cycle is kept
  always @* begin
    load_arm_d = load_arm_o;
    if (do_load) begin
      load_arm_d = 1'b0;
    end
    if (load_arm_set_i) begin
      load_arm_d = 1'b1;
    end
  end

  // sequencer state
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // arm flag, visible to software
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_arm_o <= `PBRC_RST_BIT;
    end else begin
      load_arm_o <= load_arm_d;
    end
  end

  // exported load pulse
  // registered, so peers see it in the cycle the new copies appear
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_event_o <= `PBRC_RST_BIT;
    end else begin
      load_event_o <= do_load;
    end
  end

  // one strobe for all copies
  // the five copies share do_load, so a load can never leave some values
  // old and others new; this costs one fanout net of four words and one bit.

  // phase value
  pbrc_copy_pair #(
    .W(VAL_W)
  ) u_phase (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(phase_we_i),
    .wdata_i(phase_wdata_i),
    .load_i(do_load),
    .hold_o(phase_hold_o),
    .oper_o(phase_value_pair_o)
  );

  // duty value
  pbrc_copy_pair #(
    .W(VAL_W)
  ) u_duty (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(duty_we_i),
    .wdata_i(duty_wdata_i),
    .load_i(do_load),
    .hold_o(duty_hold_o),
    .oper_o(duty_value_pair_o)
  );

  // period value; its operating copy also feeds the period event
  pbrc_copy_pair #(
    .W(VAL_W)
  ) u_period (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(period_we_i),
    .wdata_i(period_wdata_i),
    .load_i(do_load),
    .hold_o(period_hold_o),
    .oper_o(period_operating_value_o)
  );

  // offset value
  pbrc_copy_pair #(
    .W(VAL_W)
  ) u_offset (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(offset_we_i),
    .wdata_i(offset_wdata_i),
    .load_i(do_load),
    .hold_o(offset_hold_o),
    .oper_o(offset_value_pair_o)
  );

  // offset-mode option, a one-bit copy
  pbrc_copy_pair #(
    .W(1)
  ) u_offset_mode (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(offset_mode_we_i),
    .wdata_i(offset_mode_option_i),
    .load_i(do_load),
    .hold_o(offset_mode_hold_o),
    .oper_o(offset_mode_option_o)
  );

endmodule // pbrc_reload

// one holding copy and the operating copy behind it; every buffered value
// uses one of these so that all of them follow the same load strobe
module pbrc_copy_pair #(
  parameter W = `PBRC_VAL_W
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire we_i,
  input wire [W-1:0] wdata_i,
  input wire load_i,
  output reg [W-1:0] hold_o,
  output reg [W-1:0] oper_o
);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_o <= {W{`PBRC_RST_BIT}};
    end else if (we_i) begin
      hold_o <= wdata_i;
    end
  end

  // operating copy
  // a write in the load cycle is not taken: the value held before that
  // edge loads, and the new one waits in the holding copy for the next load
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      oper_o <= {W{`PBRC_RST_BIT}};
    end else if (load_i) begin
      oper_o <= hold_o;
    end
  end

endmodule // pbrc_copy_pair

// File: pbrc_reload_sva.sv
/*
  concurrent checks on the ports of one pbrc_reload channel.
  assumes the single clock and the synchronous active-high reset of the channel.
*/
`timescale 1ns/100ps
module pbrc_reload_sva #(
  parameter VAL_W = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire phase_we_i,
  input wire load_arm_set_i,
  input wire load_trigger_mode_i,
  input wire load_arm_o,
  input wire load_event_o,
  input wire [VAL_W-1:0] pwm_counter_i,
  input wire [VAL_W-1:0] phase_wdata_i,
  input wire [VAL_W-1:0] phase_hold_o,
  input wire [VAL_W-1:0] phase_value_pair_o,
  input wire [VAL_W-1:0] period_operating_value_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire pev = pwm_counter_i == period_operating_value_o;
  wire ev = load_event_o;
  // immediate arm standing at a period event
  sequence s_imm_ready;
    load_arm_o && !load_trigger_mode_i && pev;
  endsequence
  a_hold_write: assert property (phase_we_i |=> phase_hold_o == $past(phase_wdata_i)) else $error("hold");
  a_ops_steady: assert property (!ev |-> $stable(phase_value_pair_o)) else $error("steady");
  a_load_armed: assert property (ev |-> $past(load_arm_o)) else $error("unarmed");
  a_load_copy: assert property (ev |-> phase_value_pair_o == $past(phase_hold_o)) else $error("copy");
  a_load_period: assert property (ev |-> $past(pev)) else $error("period");
  a_arm_clear: assert property (ev && !$past(load_arm_set_i) |-> !load_arm_o) else $error("clear");
  a_imm_load: assert property (s_imm_ready |=> ev) else $error("late");
  a_arm_skip: assert property (load_arm_set_i && !load_arm_o && pev |=> !ev) else $error("skip");
endmodule // pbrc_reload_sva
bind pbrc_reload pbrc_reload_sva #(
  .VAL_W(VAL_W)
) chk (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .phase_we_i(phase_we_i),
  .load_arm_set_i(load_arm_set_i),
  .load_trigger_mode_i(load_trigger_mode_i),
  .load_arm_o(load_arm_o),
  .load_event_o(load_event_o),
  .pwm_counter_i(pwm_counter_i),
  .phase_wdata_i(phase_wdata_i),
  .phase_hold_o(phase_hold_o),
  .phase_value_pair_o(phase_value_pair_o),
  .period_operating_value_o(period_operating_value_o)
);

// File: pbrc_peer.sv
/* other channels: one-cycle reload pulse on a chosen lane; asked just after a clock edge */
`timescale 1ns/100ps
module pbrc_peer (
  input wire clk_i,
  input wire fire_i,
  input wire [1:0] src_i,
  output reg [3:0] load_event_o
);
  always @(posedge clk_i) begin
    load_event_o <= fire_i ? 4'h1 << src_i : 4'h0;
  end
endmodule // pbrc_peer

// File: pbrc_reload_test.sv
/* bench for pbrc_reload; peer pulses come from pbrc_peer; assumes the checker binds itself */
`timescale 1ns/100ps
module pbrc_reload_test;
  reg clk_i = 1'h0, rst = 1'h1, we = 1'h0, arm = 1'h0, md = 1'h0, fire = 1'h0;
  reg [1:0] sel = 2'h0, lane = 2'h0;
  reg [15:0] cnt = 16'h0, per = 16'h0;
  reg [64:0] nx = 65'h0, w, q[$];
  reg [64:0] pv = 65'h0;
  wire [64:0] ov, hv;
  wire [3:0] pe;
  wire lev, la;
  int n_mismatch = 0, num_checks = 0, s;
  initial forever #50 clk_i = ~clk_i;
  pbrc_peer peer (.clk_i(clk_i), .fire_i(fire), .src_i(lane), .load_event_o(pe));
  pbrc_reload uut (.clk_i(clk_i), .sys_rst_i(rst), .pwm_counter_i(cnt), .phase_wdata_i(nx[15:0]), .phase_we_i(we),
    .duty_wdata_i(nx[31:16]), .duty_we_i(we), .period_wdata_i(nx[47:32]), .period_we_i(we),
    .offset_wdata_i(nx[63:48]), .offset_we_i(we), .offset_mode_option_i(nx[64]), .offset_mode_we_i(we),
    .load_arm_set_i(arm), .load_trigger_mode_i(md), .trigger_source_select_i(sel), .peer_load_event_i(pe),
    .phase_hold_o(hv[15:0]), .duty_hold_o(hv[31:16]), .period_hold_o(hv[47:32]), .offset_hold_o(hv[63:48]),
    .offset_mode_hold_o(hv[64]),
    .phase_value_pair_o(ov[15:0]), .duty_value_pair_o(ov[31:16]), .period_operating_value_o(ov[47:32]),
    .offset_value_pair_o(ov[63:48]), .offset_mode_option_o(ov[64]), .load_arm_o(la), .load_event_o(lev));
  task chk(input ok, input string m);
    num_checks++;
    if (ok !== 1'h1) begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // off-period counter is the inverse, so it never matches by accident
  task step(input h, input a, input [2:0] f, input e);
    cnt <= h ? per : ~per;
    arm <= a;
    {fire, lane} <= f;
    we <= e;
    @(posedge clk_i);
  endtask
  task tally_and_finish;
    chk(q.size() == 0, "missing load");
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) if (lev === 1'h1) chk(ov === q.pop_front(), "copies");
  initial begin
    s = $urandom(32'h2DB5);
    repeat (5) @(posedge clk_i);
    rst <= 1'h0;
    for (s = 0; s < 5; s++) begin
      w = 65'({$urandom, $urandom, $urandom});
      q.push_back(w);
      nx <= w;
      md <= s < 4;
      sel <= s[1:0];
      step(1'h0, 1'h0, 3'h0, 1'h1);
      step(1'h1, 1'h1, 3'h0, 1'h0);
      chk(hv === w, "holding copy");
      chk(ov === pv, "operating moved");
      if (s < 4) begin
        step(1'h1, 1'h0, {1'h1, sel + 2'h1}, 1'h0);
        chk(la === 1'h1, "arm lost");
        step(1'h1, 1'h0, {1'h1, sel}, 1'h0);
        step(1'h1, 1'h0, 3'h0, 1'h0);
        repeat (2) step(1'h0, 1'h0, 3'h0, 1'h0);
        chk(q.size() == 1, "early load");
      end
      step(1'h1, 1'h0, 3'h0, 1'h0);
      per = w[47:32];
      pv = w;
    end
    repeat (2) step(1'h0, 1'h0, 3'h0, 1'h0);
    chk(la === 1'h0, "arm kept");
    tally_and_finish;
  end
endmodule // pbrc_reload_test
